// ---- verilog/rtcw_reset_seq.sv ----
// reset sequencing, watchdog, sleep wake-up and configuration word store
// Overview of operation
// - the watchdog is switched on by a configuration bit and counts ticks of its own RC oscillator.
// - the oscillator start-up timer holds the core in reset, or stopped after a sleep wake, until the crystal has run long enough.
// - after power-up only, a 72 ms delay keeps the core in reset while the supply settles.
// - a detected brown-out forces a device reset.
// - sleep ends on an external reset, a watchdog wake-up or an interrupt.
// - a configuration bit reads 0 when programmed and 1 when erased, and options follow it.
// - the configuration word lives at address 2007h, outside user program space.
// - the range 2000h-3FFFh is reachable only in programming mode.
// - configuration bit 13 at 0 code-protects program memory from address zero, at 1 leaves it open.
`timescale 1ns/1ps
module rtcw_reset_seq #(
  parameter int PWRUP_CYCLES = rtcw_pkg::PWRUP_CYCLES
) (
  // clock and power-on reset
  input  wire logic          ref_clk,
  input  wire logic          resetn,
  // reset and wake sources
  input  wire logic          ext_reset_n,
  input  wire logic          brownout_detect,
  input  wire logic          irq_pending,
  // oscillators, sampled as levels
  input  wire logic          xtal_osc,
  input  wire logic          wdog_rc_osc,
  // core requests
  input  wire logic          sleep_req,
  input  wire logic          wdog_clear,
  // programming port
  input  wire logic          prog_mode,
  input  wire logic          prog_wr,
  input  wire logic          prog_rd,
  input  wire logic [13:0]   prog_addr,
  input  wire logic [13:0]   prog_wdata,
  output logic [13:0]        prog_rdata,
  output logic               prog_rvalid,
  // core control and status
  output logic               cpu_reset_n,
  output logic               cpu_run,
  output logic               wake_pulse,
  output rtcw_pkg::rtcw_cfg_s   cfg,
  output rtcw_pkg::rtcw_cause_s cause
);
  rtcw_pkg::rtcw_state_e state_reg, state_next;
  logic                  por_reg, por_next;
  logic                  waking_reg, waking_next;
  logic                  rst_n_reg, rst_n_next;
  logic                  run_reg, run_next;
  logic                  wake_reg, wake_next;
  rtcw_pkg::rtcw_cause_s cause_reg, cause_next;
  logic [13:0]           cfg_word_reg, cfg_word_next;
  rtcw_pkg::rtcw_cfg_s   cfg_reg, cfg_next;
  logic [13:0]           rdata_reg, rdata_next;
  logic                  rvalid_reg, rvalid_next;
  logic                  xtal_prev_reg, rc_prev_reg;
  logic                  xtal_tick, rc_tick;
  logic                  pwrup_done, oscst_done, wdog_done;
  logic                  wdog_clr, wdog_fire, ext_rst, bo_rst, rst_src;
  logic [22:0]           pwrup_seen_reg, pwrup_seen_next;

  assign xtal_tick = xtal_osc && !xtal_prev_reg;
  assign rc_tick   = wdog_rc_osc && !rc_prev_reg;

  // reset sources; programming mode also holds the core
  assign ext_rst   = !ext_reset_n && cfg_reg.mclr_en;
  assign bo_rst    = brownout_detect && cfg_reg.brownout_en;
  assign rst_src   = prog_mode || ext_rst || bo_rst;
  assign wdog_fire = cfg_reg.wdog_en && wdog_done;
  // watchdog restarts on clear, on sleep entry and whenever it is not watching
  assign wdog_clr  = wdog_clear || !cfg_reg.wdog_en
                  || (state_reg == rtcw_pkg::ST_RUN && sleep_req)
                  || !(state_reg == rtcw_pkg::ST_RUN || state_reg == rtcw_pkg::ST_SLEEP);

  rtcw_tick_counter #(.WIDTH(rtcw_pkg::PWRUP_WIDTH)) u_pwrup (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .clear   (state_reg != rtcw_pkg::ST_PWRUP),
    .tick    (1'b1),
    .limit   (rtcw_pkg::PWRUP_WIDTH'(PWRUP_CYCLES)),
    .done    (pwrup_done)
  );

  rtcw_tick_counter #(.WIDTH(rtcw_pkg::OSCST_WIDTH)) u_oscst (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .clear   (state_reg != rtcw_pkg::ST_OSCST),
    .tick    (xtal_tick),
    .limit   (rtcw_pkg::OSCST_WIDTH'(rtcw_pkg::OSCST_OSC_TICKS)),
    .done    (oscst_done)
  );

  // rc ticks only, so the timeout holds even if the main clock source drifts
  rtcw_tick_counter #(.WIDTH(rtcw_pkg::WDOG_WIDTH)) u_wdog (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .clear   (wdog_clr),
    .tick    (rc_tick),
    .limit   (rtcw_pkg::WDOG_WIDTH'(rtcw_pkg::WDOG_RC_TICKS)),
    .done    (wdog_done)
  );

  // sequencer
  always_comb begin
    state_next  = state_reg;
    por_next    = por_reg;
    waking_next = waking_reg;
    cause_next  = cause_reg;
    wake_next   = 1'b0;
    case (state_reg)
      rtcw_pkg::ST_HOLD: begin
        if (!rst_src) begin
          por_next   = 1'b0;
          state_next = (por_reg && cfg_reg.pwrup_en) ? rtcw_pkg::ST_PWRUP
                                                     : rtcw_pkg::ST_OSCST;
        end
      end
      rtcw_pkg::ST_PWRUP: begin
        if (pwrup_done) begin
          state_next = rtcw_pkg::ST_OSCST;
        end
      end
      rtcw_pkg::ST_OSCST: begin
        if (oscst_done) begin
          state_next  = rtcw_pkg::ST_RUN;
          wake_next   = waking_reg;
          waking_next = 1'b0;
        end
      end
      rtcw_pkg::ST_RUN: begin
        if (wdog_fire) begin
          state_next = rtcw_pkg::ST_HOLD;
          cause_next = '{power_on: 1'b0, brownout: 1'b0, external: 1'b0,
                         watchdog: 1'b1, wake: 1'b0};
        end else if (sleep_req) begin
          state_next = rtcw_pkg::ST_SLEEP;
        end
      end
      rtcw_pkg::ST_SLEEP: begin
        if (wdog_fire || irq_pending) begin
          state_next  = rtcw_pkg::ST_OSCST;
          waking_next = 1'b1;
          cause_next  = '{power_on: 1'b0, brownout: 1'b0, external: 1'b0,
                          watchdog: wdog_fire, wake: 1'b1};
        end
      end
      default: begin
        state_next = rtcw_pkg::ST_HOLD;
      end
    endcase
    // any reset source overrides the sequence, including an external reset in sleep
    if (rst_src) begin
      state_next  = rtcw_pkg::ST_HOLD;
      waking_next = 1'b0;
      wake_next   = 1'b0;
      cause_next  = '{power_on: por_reg, brownout: bo_rst, external: ext_rst,
                      watchdog: 1'b0, wake: 1'b0};
    end
    // a wake restarts the crystal but the core keeps its context
    rst_n_next = (state_next == rtcw_pkg::ST_RUN) || (state_next == rtcw_pkg::ST_SLEEP)
              || waking_next;
    run_next   = (state_next == rtcw_pkg::ST_RUN);
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg     <= rtcw_pkg::ST_HOLD;
      por_reg       <= 1'b1;
      waking_reg    <= 1'b0;
      rst_n_reg     <= 1'b0;
      run_reg       <= 1'b0;
      wake_reg      <= 1'b0;
      cause_reg     <= '{power_on: 1'b1, brownout: 1'b0, external: 1'b0,
                         watchdog: 1'b0, wake: 1'b0};
      xtal_prev_reg <= 1'b0;
      rc_prev_reg   <= 1'b0;
    end else begin
      state_reg     <= state_next;
      por_reg       <= por_next;
      waking_reg    <= waking_next;
      rst_n_reg     <= rst_n_next;
      run_reg       <= run_next;
      wake_reg      <= wake_next;
      cause_reg     <= cause_next;
      xtal_prev_reg <= xtal_osc;
      rc_prev_reg   <= wdog_rc_osc;
    end
  end

  // check helper: cycles spent in the power-up delay
  always_comb begin
    pwrup_seen_next = '0;
    if (state_reg == rtcw_pkg::ST_PWRUP) begin
      pwrup_seen_next = pwrup_seen_reg + 23'h000001;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pwrup_seen_reg <= '0;
    end else begin
      pwrup_seen_reg <= pwrup_seen_next;
    end
  end

  // configuration word store and programming access
  always_comb begin
    cfg_word_next = cfg_word_reg;
    rdata_next    = rdata_reg;
    rvalid_next   = 1'b0;
    if (prog_mode && prog_wr && prog_addr == rtcw_pkg::CFG_WORD_ADDR) begin
      cfg_word_next = prog_wdata;
    end
    if (prog_mode && prog_rd) begin
      rvalid_next = 1'b1;
      if (prog_addr == rtcw_pkg::CFG_WORD_ADDR) begin
        rdata_next = cfg_word_reg;
      end else if (prog_addr >= rtcw_pkg::CFG_SPACE_LO) begin
        rdata_next = rtcw_pkg::CFG_SPACE_IDLE;
      end else begin
        rdata_next = rtcw_pkg::USER_SPACE_RD;
      end
    end
    // erased bits read 1, so enables that are active low are inverted here
    cfg_next.code_protect = !cfg_word_reg[rtcw_pkg::CFG_PROTECT_BIT];
    cfg_next.brownout_en  = cfg_word_reg[rtcw_pkg::CFG_BO_EN_BIT];
    cfg_next.mclr_en      = cfg_word_reg[rtcw_pkg::CFG_MCLRE_BIT];
    cfg_next.pwrup_en     = !cfg_word_reg[rtcw_pkg::CFG_PWRUP_EN_BIT];
    cfg_next.wdog_en      = cfg_word_reg[rtcw_pkg::CFG_WDOG_EN_BIT];
  end

  // resetn models first power; the word itself is non-volatile across device resets
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_word_reg <= rtcw_pkg::CFG_WORD_RESET;
      cfg_reg      <= '{code_protect: 1'b0, brownout_en: 1'b1, mclr_en: 1'b1,
                        pwrup_en: 1'b0, wdog_en: 1'b1};
      rdata_reg    <= '0;
      rvalid_reg   <= 1'b0;
    end else begin
      cfg_word_reg <= cfg_word_next;
      cfg_reg      <= cfg_next;
      rdata_reg    <= rdata_next;
      rvalid_reg   <= rvalid_next;
    end
  end

  assign prog_rdata  = rdata_reg;
  assign prog_rvalid = rvalid_reg;
  assign cpu_reset_n = rst_n_reg;
  assign cpu_run     = run_reg;
  assign wake_pulse  = wake_reg;
  assign cfg         = cfg_reg;
  assign cause       = cause_reg;

  // checks
  property p_cfg_read;
    @(posedge ref_clk) disable iff (!resetn)
      (prog_mode && prog_rd && !prog_wr && prog_addr == rtcw_pkg::CFG_WORD_ADDR)
      |=> prog_rvalid && prog_rdata == $past(cfg_word_reg);
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("config word read wrong");

  property p_cfg_locked;
    @(posedge ref_clk) disable iff (!resetn)
      !prog_mode |=> $stable(cfg_word_reg) && !prog_rvalid;
  endproperty
  a_cfg_locked: assert property (p_cfg_locked) else $error("config space reached");

  property p_brownout;
    @(posedge ref_clk) disable iff (!resetn)
      (brownout_detect && cfg_reg.brownout_en) |=> !cpu_reset_n ##1 !cpu_reset_n;
  endproperty
  a_brownout: assert property (p_brownout) else $error("brown-out did not reset");

  // the helper counts every cycle spent in the delay, so a short exit shows up
  property p_pwrup_full;
    @(posedge ref_clk) disable iff (!resetn)
      (state_reg == rtcw_pkg::ST_PWRUP && state_next == rtcw_pkg::ST_OSCST)
      |-> pwrup_seen_reg == rtcw_pkg::PWRUP_WIDTH'(PWRUP_CYCLES);
  endproperty
  a_pwrup_full: assert property (p_pwrup_full) else $error("power-up delay cut short");

  property p_pwrup_skip;
    @(posedge ref_clk) disable iff (!resetn)
      (state_reg == rtcw_pkg::ST_HOLD && !rst_src && !cfg_reg.pwrup_en)
      |=> state_reg == rtcw_pkg::ST_OSCST ##1 !cpu_run;
  endproperty
  a_pwrup_skip: assert property (p_pwrup_skip) else $error("disabled delay ran");

  property p_oscst_gate;
    @(posedge ref_clk) disable iff (!resetn)
      $rose(cpu_run) |-> $past(oscst_done);
  endproperty
  a_oscst_gate: assert property (p_oscst_gate) else $error("run before crystal stable");

  property p_wdog_reset;
    @(posedge ref_clk) disable iff (!resetn)
      (state_reg == rtcw_pkg::ST_RUN && wdog_fire && !rst_src)
      |=> !cpu_reset_n && cause.watchdog;
  endproperty
  a_wdog_reset: assert property (p_wdog_reset) else $error("watchdog did not reset");

  property p_sleep_wake;
    @(posedge ref_clk) disable iff (!resetn)
      (state_reg == rtcw_pkg::ST_SLEEP && !rst_src && (irq_pending || wdog_fire))
      |=> cpu_reset_n && cause.wake && state_reg == rtcw_pkg::ST_OSCST;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake missed");

  property p_protect_bit;
    @(posedge ref_clk) disable iff (!resetn)
      ##1 cfg.code_protect == !$past(cfg_word_reg[rtcw_pkg::CFG_PROTECT_BIT]);
  endproperty
  a_protect_bit: assert property (p_protect_bit) else $error("code protect polarity");

  c_power_up: cover property (@(posedge ref_clk) disable iff (!resetn) $rose(cpu_run));
  c_wdog_rst: cover property (@(posedge ref_clk) disable iff (!resetn)
                              state_reg == rtcw_pkg::ST_RUN && wdog_fire);
  c_wake:     cover property (@(posedge ref_clk) disable iff (!resetn) wake_pulse);
  c_prog:     cover property (@(posedge ref_clk) disable iff (!resetn)
                              prog_mode && prog_wr && prog_addr == rtcw_pkg::CFG_WORD_ADDR);
endmodule : rtcw_reset_seq

// ---- verilog/rtcw_pkg.sv ----
// constants and carriers for the reset timing and configuration word block
package rtcw_pkg;
  // clock and start-up timing
  localparam int CLK_FREQ_MHZ      = 100;
  localparam int PWRUP_DELAY_MS    = 72;
  localparam int PWRUP_CYCLES      = PWRUP_DELAY_MS * 1000 * CLK_FREQ_MHZ;
  localparam int PWRUP_WIDTH       = 23;
  localparam int OSCST_OSC_TICKS   = 1024;
  localparam int OSCST_WIDTH       = 11;
  localparam int WDOG_RC_TICKS     = 2048;
  localparam int WDOG_WIDTH        = 12;
  // configuration word and its address space
  localparam logic [13:0] CFG_WORD_ADDR  = 14'h2007;
  localparam logic [13:0] CFG_SPACE_LO   = 14'h2000;
  localparam logic [13:0] CFG_WORD_RESET = 14'h3FFF;
  localparam logic [13:0] CFG_SPACE_IDLE = 14'h3FFF;
  localparam logic [13:0] USER_SPACE_RD  = 14'h0000;
  // field positions in the configuration word
  localparam int CFG_PROTECT_BIT  = 13;
  localparam int CFG_BO_EN_BIT    = 6;
  localparam int CFG_MCLRE_BIT    = 5;
  localparam int CFG_PWRUP_EN_BIT = 3;
  localparam int CFG_WDOG_EN_BIT  = 2;

  typedef enum logic [2:0] {
    ST_HOLD  = 3'b000,
    ST_PWRUP = 3'b001,
    ST_OSCST = 3'b010,
    ST_RUN   = 3'b011,
    ST_SLEEP = 3'b100
  } rtcw_state_e;

  // decoded device options, all active high
  typedef struct packed {
    logic code_protect;
    logic brownout_en;
    logic mclr_en;
    logic pwrup_en;
    logic wdog_en;
  } rtcw_cfg_s;

  // cause of the last reset or wake
  typedef struct packed {
    logic power_on;
    logic brownout;
    logic external;
    logic watchdog;
    logic wake;
  } rtcw_cause_s;
endpackage : rtcw_pkg

// ---- verilog/rtcw_tick_counter.sv ----
// saturating tick counter used by each start-up and watchdog timer
`timescale 1ns/1ps
module rtcw_tick_counter #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  // control
  input  wire logic             clear,
  input  wire logic             tick,
  input  wire logic [WIDTH-1:0] limit,
  // status
  output logic                  done
);
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;

  assign done = (count_reg == limit);

  always_comb begin
    count_next = count_reg;
    if (clear) begin
      count_next = '0;
    end else if (tick && !done) begin
      count_next = count_reg + WIDTH'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule : rtcw_tick_counter

// ---- bench/rtcw_osc_model.sv ----
// crystal and watchdog rc oscillator model facing the sequencer
`timescale 1ns/1ps
module rtcw_osc_model #(
  parameter int RC_DIV = 3
) (
  // reference timebase
  input  wire logic ref_clk,
  // crystal enable, low while the crystal has not started
  input  wire logic xtal_on,
  // oscillator levels
  output logic      xtal_osc,
  output logic      wdog_rc_osc
);
  int rc_cnt = 0;
  initial begin
    xtal_osc = 1'b0;
    wdog_rc_osc = 1'b0;
  end
  // a stopped crystal rests low, so it gives no stray start-up tick
  always @(negedge ref_clk) begin
    xtal_osc <= xtal_on ? ~xtal_osc : 1'b0;
  end
  // rc runs from its own divider, never from the crystal
  always @(negedge ref_clk) begin
    if (rc_cnt == RC_DIV - 1) begin
      rc_cnt <= 0;
      wdog_rc_osc <= ~wdog_rc_osc;
    end else begin
      rc_cnt <= rc_cnt + 1;
    end
  end
endmodule : rtcw_osc_model

// ---- bench/tb_top.sv ----
// self-checking bench for the reset sequencer and configuration word
`timescale 1ns/1ps
module tb_top;
  logic        ref_clk = 1'b0;
  logic        resetn, ext_reset_n, brownout_detect, irq_pending, xtal_osc, wdog_rc_osc;
  logic        sleep_req, wdog_clear, prog_mode, prog_wr, prog_rd, prog_rvalid;
  logic        cpu_reset_n, cpu_run, wake_pulse, xtal_on;
  logic [13:0] prog_addr, prog_wdata, prog_rdata, d, w;
  rtcw_pkg::rtcw_cfg_s   cfg;
  rtcw_pkg::rtcw_cause_s cause;
  int          error_cnt = 0;
  int          check_count = 0;
  int          n, seed;

  always #5 ref_clk = ~ref_clk;

  rtcw_osc_model osc_u (.ref_clk(ref_clk), .xtal_on(xtal_on), .xtal_osc(xtal_osc),
    .wdog_rc_osc(wdog_rc_osc));

  // short power-up delay keeps the run brief
  rtcw_reset_seq #(.PWRUP_CYCLES(20)) dut_u (.ref_clk(ref_clk), .resetn(resetn),
    .ext_reset_n(ext_reset_n), .brownout_detect(brownout_detect), .irq_pending(irq_pending),
    .xtal_osc(xtal_osc), .wdog_rc_osc(wdog_rc_osc), .sleep_req(sleep_req),
    .wdog_clear(wdog_clear), .prog_mode(prog_mode), .prog_wr(prog_wr), .prog_rd(prog_rd),
    .prog_addr(prog_addr), .prog_wdata(prog_wdata), .prog_rdata(prog_rdata),
    .prog_rvalid(prog_rvalid), .cpu_reset_n(cpu_reset_n), .cpu_run(cpu_run),
    .wake_pulse(wake_pulse), .cfg(cfg), .cause(cause));

  task automatic final_report;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  task automatic check(input string name, input logic [13:0] seen, input logic [13:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // erased bit reads 1; protect and delay enable are the inverted bits
  function automatic logic [13:0] exp_cfg(input logic [13:0] v);
    return {9'h000, ~v[13], v[6], v[5], ~v[3], v[2]};
  endfunction : exp_cfg

  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask : cyc

  // which 0 watches core reset, 1 watches core run
  task automatic wait_sig(input int which, input logic v, input int lim, output int k);
    k = 0;
    while (((which == 0) ? cpu_reset_n : cpu_run) !== v && k < lim) begin
      @(negedge ref_clk);
      k++;
    end
    check("wait_done", 14'(k < lim), 14'h0001);
  endtask : wait_sig

  task automatic prog_read(input logic [13:0] a, input logic vld, output logic [13:0] q);
    prog_rd = 1'b1;
    prog_addr = a;
    cyc(1);
    prog_rd = 1'b0;
    check("rvalid", 14'(prog_rvalid), 14'(vld));
    q = prog_rdata;
    cyc(1);
  endtask : prog_read

  task automatic prog_write(input logic [13:0] a, input logic [13:0] v);
    prog_wr = 1'b1;
    prog_addr = a;
    prog_wdata = v;
    cyc(1);
    prog_wr = 1'b0;
    cyc(1);
  endtask : prog_write

  task automatic go_sleep;
    sleep_req = 1'b1;
    cyc(1);
    sleep_req = 1'b0;
    cyc(1);
  endtask : go_sleep

  task automatic pulse_clr;
    wdog_clear = 1'b1;
    cyc(1);
    wdog_clear = 1'b0;
  endtask : pulse_clr

  // about 95000 cycles, well past the roughly 62000 the scenarios take
  initial begin
    #950000;
    error_cnt++;
    final_report();
  end

  initial begin
    seed = 32'h889AE62E;
    {resetn, brownout_detect, irq_pending, sleep_req, wdog_clear} = '0;
    {prog_mode, prog_wr, prog_rd} = '0;
    ext_reset_n = 1'b1;
    xtal_on = 1'b1;
    prog_addr = '0;
    prog_wdata = '0;
    cyc(6);
    check("cfg_por", 14'(cfg), 14'h000D);
    check("cause_por", 14'(cause), 14'h0010);
    check("core_rst_por", 14'(cpu_reset_n), 14'h0000);
    resetn = 1'b1;
    wait_sig(1, 1'b1, 2300, n);
    prog_mode = 1'b1;
    cyc(2);
    check("prog_holds", 14'(cpu_reset_n), 14'h0000);
    prog_read(14'h2007, 1'b1, d);
    check("word_erased", d, 14'h3FFF);
    prog_read(14'h3FFF, 1'b1, d);
    check("cfg_space", d, 14'h3FFF);
    prog_read(14'h07FF, 1'b1, d);
    check("user_space", d, 14'h0000);
    for (int i = 0; i < 6; i++) begin
      w = 14'($random(seed));
      prog_write(14'h2007, w);
      prog_read(14'h2007, 1'b1, d);
      check("word_rd", d, w);
      check("cfg_decode", 14'(cfg), exp_cfg(w));
    end
    prog_write(14'h2008, ~w);
    prog_read(14'h2007, 1'b1, d);
    check("other_addr", d, w);
    // protect on, delay enabled, watchdog, pin reset and brown-out on
    prog_write(14'h2007, 14'h1FF7);
    prog_mode = 1'b0;
    prog_write(14'h2007, 14'h0000);
    prog_read(14'h2007, 1'b0, d);
    prog_mode = 1'b1;
    prog_read(14'h2007, 1'b1, d);
    check("word_kept", d, 14'h1FF7);
    check("cp_on", 14'(cfg.code_protect), 14'h0001);
    xtal_on = 1'b0;
    prog_mode = 1'b0;
    cyc(3000);
    check("ost_holds", 14'(cpu_reset_n), 14'h0000);
    xtal_on = 1'b1;
    wait_sig(0, 1'b1, 2300, n);
    check("no_delay_late", 14'(n >= 2040 && n <= 2062), 14'h0001);
    brownout_detect = 1'b1;
    cyc(1);
    check("bo_reset", 14'({cpu_reset_n, cause.brownout}), 14'h0001);
    brownout_detect = 1'b0;
    wait_sig(1, 1'b1, 2300, n);
    ext_reset_n = 1'b0;
    cyc(1);
    check("ext_reset", 14'({cpu_reset_n, cause.external}), 14'h0001);
    ext_reset_n = 1'b1;
    wait_sig(1, 1'b1, 2300, n);
    go_sleep();
    check("asleep", 14'({cpu_run, cpu_reset_n}), 14'h0001);
    irq_pending = 1'b1;
    wait_sig(1, 1'b1, 2300, n);
    check("irq_wake", 14'({wake_pulse, cause.wake, cpu_reset_n}), 14'h0007);
    irq_pending = 1'b0;
    go_sleep();
    ext_reset_n = 1'b0;
    cyc(1);
    check("sleep_ext", 14'({cpu_reset_n, cause.external}), 14'h0001);
    ext_reset_n = 1'b1;
    wait_sig(1, 1'b1, 2300, n);
    repeat (4) begin
      pulse_clr();
      cyc(4000);
    end
    check("wdog_cleared", 14'(cpu_reset_n), 14'h0001);
    // crystal stopped: the watchdog must still time out on its own rc
    xtal_on = 1'b0;
    pulse_clr();
    wait_sig(0, 1'b0, 13000, n);
    check("wdog_period", 14'(n >= 12270 && n <= 12310), 14'h0001);
    check("wdog_cause", 14'(cause.watchdog), 14'h0001);
    xtal_on = 1'b1;
    wait_sig(1, 1'b1, 2300, n);
    pulse_clr();
    go_sleep();
    wait_sig(1, 1'b1, 15000, n);
    check("wdog_wake", 14'({cpu_reset_n, cause.wake}), 14'h0003);
    // second power-up: programming holds the core, so the delay can be enabled first
    resetn = 1'b0;
    prog_mode = 1'b1;
    cyc(2);
    check("cause_por2", 14'(cause), 14'h0010);
    resetn = 1'b1;
    prog_write(14'h2007, 14'h3FF7);
    prog_mode = 1'b0;
    wait_sig(1, 1'b1, 2300, n);
    check("delay_len", 14'(n >= 2060 && n <= 2090), 14'h0001);
    final_report();
  end
endmodule : tb_top
